// ### uart_line_format_control.sv
// Serial transceiver with programmable character format, APB slave
//
// How it works
// - Format bits 1:0 pick 5, 6, 7 or 8 data bits for both transmit and receive.
// - With the stop-length bit clear the transmitter sends exactly one stop bit.
// - With the stop-length bit set and 5 data bits the transmitter sends one and a half stop bits.
// - The receiver samples and checks only the first stop bit of each character.
// - The format register reads back bits 7:0 of what software last wrote; bits 31:8 read as zero.
// - With the stop-length bit set and 6, 7 or 8 data bits the transmitter sends two stop bits.
`timescale 1ns/1ns
`include "line_format_params.svh"
module uart_line_format_control
  import line_format_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in,
  output logic serial_out
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [3:0] data_bits(input logic [1:0] len);
    data_bits = 4'd5 + {2'b00, len};
  endfunction

  // Stop time in half bit periods
  function automatic logic [2:0] stop_halves(input format_t f);
    if (!f.stop_long) stop_halves = 3'd2;
    else if (f.len == 2'b00) stop_halves = 3'd3;
    else stop_halves = 3'd4;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus
  format_t fmt_q, fmt_d;
  logic [15:0] div_q, div_d;
  logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
  logic txpend_q, txpend_d, rxvalid_q, rxvalid_d, ferr_q, ferr_d, ovr_q, ovr_d;
  logic [31:0] prdata_d;
  logic pready_q, pready_d, pslverr_d;
  logic access, wr, rd, known, rx_done, rx_ferr, tx_take, tx_busy;
  logic [7:0] rx_word;

  assign access = psel && penable && pready_q;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  always_comb begin
    known = 1'b1;
    prdata_d = 32'h0000_0000;
    case (paddr)
      `LF_OFS_FORMAT: prdata_d = {24'h00_0000, fmt_q};
      `LF_OFS_TX_DATA: prdata_d = {24'h00_0000, txbuf_q};
      `LF_OFS_RX_DATA: prdata_d = {24'h00_0000, rxbuf_q};
      `LF_OFS_STATUS: begin
        prdata_d[`LF_ST_TX_BUSY] = tx_busy || txpend_q;
        prdata_d[`LF_ST_RX_VALID] = rxvalid_q;
        prdata_d[`LF_ST_FRAME_ERR] = ferr_q;
        prdata_d[`LF_ST_RX_OVERRUN] = ovr_q;
      end
      `LF_OFS_BAUD_DIV: prdata_d = {16'h0000, div_q};
      default: known = 1'b0;
    endcase
  end

  always_comb begin
    // One wait state: pready rises in the second access cycle
    pready_d = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !known;
    fmt_d = fmt_q;
    div_d = div_q;
    txbuf_d = txbuf_q;
    txpend_d = txpend_q && !tx_take;
    rxbuf_d = rxbuf_q;
    rxvalid_d = rxvalid_q;
    ferr_d = ferr_q;
    ovr_d = ovr_q;
    if (wr && known) begin
      case (paddr)
        `LF_OFS_FORMAT: fmt_d = format_t'(pwdata[7:0]);
        `LF_OFS_TX_DATA: begin
          txbuf_d = pwdata[7:0];
          txpend_d = 1'b1;
        end
        `LF_OFS_BAUD_DIV: div_d = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        default: ;
      endcase
    end
    // Read of data or status clears flags; new event wins over the clear
    if (rd && paddr == `LF_OFS_RX_DATA) rxvalid_d = 1'b0;
    if (rd && paddr == `LF_OFS_STATUS) begin
      ferr_d = 1'b0;
      ovr_d = 1'b0;
    end
    if (rx_done) begin
      if (rxvalid_q && !(rd && paddr == `LF_OFS_RX_DATA)) ovr_d = 1'b1;
      rxbuf_d = rx_word;
      rxvalid_d = 1'b1;
      if (rx_ferr) ferr_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= `LF_FMT_RESET;
      div_q <= `LF_BAUD_DIV_RESET;
      txbuf_q <= 8'h00;
      txpend_q <= 1'b0;
      rxbuf_q <= 8'h00;
      rxvalid_q <= 1'b0;
      ferr_q <= 1'b0;
      ovr_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      fmt_q <= fmt_d;
      div_q <= div_d;
      txbuf_q <= txbuf_d;
      txpend_q <= txpend_d;
      rxbuf_q <= rxbuf_d;
      rxvalid_q <= rxvalid_d;
      ferr_q <= ferr_d;
      ovr_q <= ovr_d;
      prdata <= prdata_d;
      pready_q <= pready_d;
      pslverr <= pslverr_d;
    end
  end
  assign pready = pready_q;

  ////////////////////////////////////////////////////////////////////////
  // Oversample tick: sixteen ticks per bit, so half a bit is eight
  logic [15:0] divcnt_q, divcnt_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = 1'b0;
    divcnt_d = divcnt_q + 16'h0001;
    if (divcnt_q >= div_q - 16'h0001) begin
      divcnt_d = 16'h0000;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divcnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      divcnt_q <= divcnt_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  tx_state_t tx_q, tx_d;
  logic [7:0] tsr_q, tsr_d;
  logic [3:0] tbit_q, tbit_d;
  logic [6:0] tcnt_q, tcnt_d;
  logic [2:0] tlen_q, tlen_d, tstop_q, tstop_d;
  logic sout_d;

  assign tx_busy = (tx_q != TX_IDLE);
  assign tx_take = (tx_q == TX_IDLE) && txpend_q;

  always_comb begin
    tx_d = tx_q;
    tsr_d = tsr_q;
    tbit_d = tbit_q;
    tcnt_d = tcnt_q;
    tlen_d = tlen_q;
    tstop_d = tstop_q;
    sout_d = 1'b1;
    case (tx_q)
      TX_IDLE: begin
        if (txpend_q) begin
          // Format latched per character so a mid-frame write cannot tear it
          tsr_d = txbuf_q;
          // Last data bit index, so eight bits still fit three
          tlen_d = 3'(data_bits(fmt_q.len) - 4'd1);
          tstop_d = stop_halves(fmt_q);
          tcnt_d = 7'd0;
          tx_d = TX_START;
        end
      end
      TX_START: begin
        sout_d = 1'b0;
        if (tick_q) begin
          tcnt_d = tcnt_q + 7'd1;
          if (tcnt_q == 7'(`LF_OVERSAMPLE - 1)) begin
            tcnt_d = 7'd0;
            tbit_d = 4'd0;
            tx_d = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        sout_d = tsr_q[0];
        if (tick_q) begin
          tcnt_d = tcnt_q + 7'd1;
          if (tcnt_q == 7'(`LF_OVERSAMPLE - 1)) begin
            tcnt_d = 7'd0;
            tsr_d = {1'b0, tsr_q[7:1]};
            tbit_d = tbit_q + 4'd1;
            if (tbit_q == {1'b0, tlen_q}) tx_d = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tick_q) begin
          tcnt_d = tcnt_q + 7'd1;
          // Stop length counted in half bits of eight ticks
          if (tcnt_q == {1'b0, tstop_q, 3'b000} - 7'd1) begin
            tcnt_d = 7'd0;
            tx_d = TX_IDLE;
          end
        end
      end
      default: tx_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= TX_IDLE;
      tsr_q <= 8'h00;
      tbit_q <= 4'd0;
      tcnt_q <= 7'd0;
      tlen_q <= 3'd0;
      tstop_q <= 3'd2;
      serial_out <= 1'b1;
    end else begin
      tx_q <= tx_d;
      tsr_q <= tsr_d;
      tbit_q <= tbit_d;
      tcnt_q <= tcnt_d;
      tlen_q <= tlen_d;
      tstop_q <= tstop_d;
      serial_out <= sout_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver: samples each bit mid-period
  rx_state_t rx_q, rx_d;
  logic [7:0] rsr_q, rsr_d;
  logic [3:0] rbit_q, rbit_d, rcnt_q, rcnt_d, rlen_q, rlen_d;
  logic done_q, done_d, rferr_q, rferr_d;

  assign rx_done = done_q;
  assign rx_ferr = rferr_q;
  // Right-justify short words, upper bits zero
  assign rx_word = rsr_q >> (4'd8 - rlen_q);

  always_comb begin
    rx_d = rx_q;
    rsr_d = rsr_q;
    rbit_d = rbit_q;
    rcnt_d = rcnt_q;
    rlen_d = rlen_q;
    done_d = 1'b0;
    rferr_d = rferr_q;
    case (rx_q)
      RX_IDLE: begin
        if (!serial_in) begin
          rcnt_d = 4'd0;
          rlen_d = data_bits(fmt_q.len);
          rx_d = RX_START;
        end
      end
      RX_START: begin
        if (tick_q) begin
          rcnt_d = rcnt_q + 4'd1;
          if (rcnt_q == 4'd7) begin
            // Glitch shorter than half a bit is dropped
            rcnt_d = 4'd0;
            rbit_d = 4'd0;
            rx_d = serial_in ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick_q) begin
          rcnt_d = rcnt_q + 4'd1;
          if (rcnt_q == 4'd15) begin
            rsr_d = {serial_in, rsr_q[7:1]};
            rbit_d = rbit_q + 4'd1;
            if (rbit_q == rlen_q - 4'd1) rx_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick_q) begin
          rcnt_d = rcnt_q + 4'd1;
          if (rcnt_q == 4'd15) begin
            // Only first stop bit sampled; extra stop bits look like idle
            rferr_d = !serial_in;
            done_d = 1'b1;
            rx_d = RX_IDLE;
          end
        end
      end
      default: rx_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= RX_IDLE;
      rsr_q <= 8'h00;
      rbit_q <= 4'd0;
      rcnt_q <= 4'd0;
      rlen_q <= 4'd8;
      done_q <= 1'b0;
      rferr_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      rsr_q <= rsr_d;
      rbit_q <= rbit_d;
      rcnt_q <= rcnt_d;
      rlen_q <= rlen_d;
      done_q <= done_d;
      rferr_q <= rferr_d;
    end
  end

endmodule // uart_line_format_control

// ### line_format_params.svh
// Register offsets, field positions, reset values and timing counts for the serial format block
`ifndef LINE_FORMAT_PARAMS_SVH
`define LINE_FORMAT_PARAMS_SVH
`define LF_OFS_FORMAT 12'h000
`define LF_OFS_TX_DATA 12'h004
`define LF_OFS_RX_DATA 12'h008
`define LF_OFS_STATUS 12'h00c
`define LF_OFS_BAUD_DIV 12'h010
`define LF_FMT_LEN_LSB 0
`define LF_FMT_STOP_BIT 2
`define LF_FMT_RESET 8'h00
`define LF_BAUD_DIV_RESET 16'h0043
`define LF_OVERSAMPLE 16
`define LF_ST_TX_BUSY 0
`define LF_ST_RX_VALID 1
`define LF_ST_FRAME_ERR 2
`define LF_ST_RX_OVERRUN 3
`endif

// ### line_format_pkg.sv
// Types shared by the serial format block
package line_format_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_STOP = 3'b011
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
  typedef struct packed {
    logic [4:0] unused;
    logic stop_long;
    logic [1:0] len;
  } format_t;
endpackage

// ### uart_line_format_control_monitor.sv
// Assertion checker for the serial format block
`timescale 1ns/1ns
module uart_line_format_control_monitor
  import line_format_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in,
  input wire logic serial_out
);
  // Assumes divider 1: one bit is 16 clocks
  logic [7:0] fmt_q, fmt_d, cnt_q, cnt_d, dend_q, dend_d, fend;
  logic [2:0] fl_q, fl_d;
  logic busy_q, busy_d;
  ////////////////////////////////////////////////////////////
  assign fend = dend_q + (!fl_q[2] ? 8'h10 : (fl_q[1:0] == 2'b00 ? 8'h18 : 8'h20));
  always_comb begin
    fmt_d = fmt_q;
    fl_d = fl_q;
    dend_d = dend_q;
    busy_d = busy_q;
    cnt_d = cnt_q + 8'h01;
    if (psel && penable && pready && pwrite && paddr == 12'h000) fmt_d = pwdata[7:0];
    if (!busy_q && !serial_out) begin
      busy_d = 1'b1;
      cnt_d = 8'h01;
      fl_d = fmt_q[2:0];
      dend_d = 8'h10 * (8'h06 + {6'h00, fmt_q[1:0]});
    end else if (busy_q && cnt_q == fend - 8'h01) begin
      busy_d = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= 8'h00;
      fl_q <= 3'h0;
      dend_q <= 8'h00;
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      fmt_q <= fmt_d;
      fl_q <= fl_d;
      dend_q <= dend_d;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_fmt;
    psel && !penable && !pwrite && paddr == 12'h000 ##2 pready;
  endsequence
  property p_rd_fmt; s_rd_fmt |-> prdata == {24'h000000, fmt_q}; endproperty
  property p_start; busy_q && cnt_q < 8'h10 |-> !serial_out; endproperty
  property p_len; busy_q && cnt_q == dend_q |-> serial_out; endproperty
  property p_stop1; busy_q && !fl_q[2] && cnt_q >= dend_q |-> serial_out; endproperty
  property p_stop15; busy_q && fl_q == 3'b100 && cnt_q >= dend_q |-> serial_out; endproperty
  property p_stop2; busy_q && fl_q[2] && fl_q[1:0] != 2'b00 && cnt_q >= dend_q |-> serial_out; endproperty
  property p_err; psel && penable && pready && paddr > 12'h010 |-> pslverr; endproperty
  a_rd_fmt: assert property (p_rd_fmt) else $error("format readback differs");
  a_start: assert property (p_start) else $error("start bit cut short");
  a_len: assert property (p_len) else $error("data length wrong");
  a_stop1: assert property (p_stop1) else $error("single stop cut short");
  a_stop15: assert property (p_stop15) else $error("stop and a half cut short");
  a_stop2: assert property (p_stop2) else $error("double stop cut short");
  a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule // uart_line_format_control_monitor

bind uart_line_format_control uart_line_format_control_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_in, .serial_out);

// ### serial_partner.sv
// Remote serial device: sends frames, measures line run lengths
`timescale 1ns/1ns
module serial_partner (
  input wire logic pclk,
  input wire logic tx_line,
  output logic rx_line,
  output logic [7:0] lo_run,
  output logic [7:0] hi_run,
  output int falls
);
  logic [7:0] run;
  logic last;
  initial begin
    rx_line = 1'b1;
    run = 8'h00;
    last = 1'b1;
    falls = 0;
    lo_run = 8'h00;
    hi_run = 8'h00;
  end
  // Saturates so long idle never wraps
  always @(posedge pclk) begin
    if (tx_line !== last) begin
      if (tx_line) lo_run <= run;
      else begin
        hi_run <= run;
        falls <= falls + 1;
      end
      run <= 8'h01;
    end else if (run != 8'hff) run <= run + 8'h01;
    last <= tx_line;
  end
  ////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] d, input int n, input logic stop);
    rx_line <= 1'b0;
    repeat (16) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rx_line <= d[i];
      repeat (16) @(posedge pclk);
    end
    rx_line <= stop;
    repeat (16) @(posedge pclk);
    if (!stop) begin
      rx_line <= 1'b1;
      @(posedge pclk);
    end
  endtask
endmodule // serial_partner

// ### test_uart_line_format_control.sv
// Testbench for the serial format block
`timescale 1ns/1ns
`include "line_format_params.svh"
module test_uart_line_format_control;
  import line_format_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_in, serial_out, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] lo_run, hi_run;
  int falls, miscompares, checked, f0, n, st;
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t %h %h", $time, a, e); end end
  uart_line_format_control u_uart_line_format_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_in, .serial_out);
  serial_partner u_serial_partner (.pclk, .tx_line(serial_out), .rx_line(serial_in), .lo_run, .hi_run, .falls);
  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Idle cycle first so no signal is assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    test_done;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, miscompares, checked} <= '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `LF_OFS_FORMAT, 0); `CHK(rd, {24'h0, `LF_FMT_RESET})
    apb(1, `LF_OFS_FORMAT, 32'h5a); apb(0, `LF_OFS_FORMAT, 0); `CHK(rd, 32'h5a)
    apb(1, `LF_OFS_BAUD_DIV, 32'h1);
    apb(0, `LF_OFS_BAUD_DIV, 0); `CHK(rd, 32'h1)
    apb(0, 12'h020, 0); `CHK(er, 1'b1)
    for (int f = 0; f < 8; f++) begin
      n = 5 + f % 4;
      st = (f < 4) ? 16 : (n == 5 ? 24 : 32);
      f0 = falls;
      apb(1, `LF_OFS_FORMAT, 32'(f));
      // Zero data so the stop time and one idle clock are the whole high run
      apb(1, `LF_OFS_TX_DATA, 0); apb(1, `LF_OFS_TX_DATA, 0);
      wait (falls == f0 + 2);
      // Run lengths settle one edge before they are read
      @(posedge pclk);
      `CHK(lo_run, 8'(16 * (n + 1)))
      // Stop time plus the one idle clock before the queued start
      `CHK(hi_run, 8'(st + 1))
      do apb(0, `LF_OFS_STATUS, 0); while (rd[`LF_ST_TX_BUSY] !== 1'b0);
      u_serial_partner.send(8'hb7, n, 1'b1);
      apb(0, `LF_OFS_RX_DATA, 0); `CHK(rd, 32'hb7 & ((32'h1 << n) - 1))
    end
    u_serial_partner.send(8'h3c, 8, 1'b1);
    u_serial_partner.send(8'hc3, 8, 1'b1);
    apb(0, `LF_OFS_STATUS, 0); `CHK(rd, 32'ha)
    apb(0, `LF_OFS_RX_DATA, 0); `CHK(rd, 32'hc3)
    u_serial_partner.send(8'h5a, 8, 1'b0);
    apb(0, `LF_OFS_STATUS, 0); `CHK(rd, 32'h6)
    apb(0, `LF_OFS_RX_DATA, 0); `CHK(rd, 32'h5a)
    test_done;
  end
endmodule // test_uart_line_format_control
